// [design/rss_cfg.svh]
// Constants of the ramp/soak sequencer: offsets, fields, resets, timing.
// Assumes a byte-addressed 32-bit Avalon-MM bus and a 50 MHz clk_sys.
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
`define RSS_OFS_CTRL   10'h000
`define RSS_OFS_LIMIT  10'h004
`define RSS_OFS_BAND   10'h008
`define RSS_OFS_LSP    10'h00C
`define RSS_OFS_STAT   10'h010
`define RSS_OFS_GSP    10'h014
`define RSS_STEP_BIT   9
`define RSS_F_CMD      1:0
`define RSS_F_PAT      6:2
`define RSS_F_UNIT     7
`define RSS_F_MODE     11:8
`define RSS_F_GSOAK    12
`define RSS_CTRL_RST   13'h0000
`define RSS_PAT_DI     5'h1F
`define RSS_PAT_ALL    5'h1E
`define RSS_MAX_MAJ    7'h63
`define RSS_MAX_MIN    6'h3B
`define RSS_HALF_FS    16'h7FFF
`define RSS_LIM_RST    32'hFFFF0000
`define RSS_CLK_NS     20
`define RSS_SEC_NS     1000000000
`define RSS_TICK_CYC   (`RSS_SEC_NS / `RSS_CLK_NS)
`define RSS_MIN_SECS   6'h3B
`endif

// [design/rss_pkg.sv]
// Types shared by the ramp/soak sequencer.
// Assumes rss_cfg.svh is compiled alongside.
package rss_pkg;
  typedef enum logic [3:0] {
    RSS_IDLE = 4'h1,
    RSS_RAMP = 4'h2,
    RSS_SOAK = 4'h4,
    RSS_END  = 4'h8
  } rss_state_type;
  typedef enum logic [1:0] {
    RSS_STOP = 2'h0,
    RSS_RUN  = 2'h1,
    RSS_HOLD = 2'h2
  } rss_cmd_type;
endpackage : rss_pkg

// [design/rss_ramp_soak_sequencer.sv]
// Ramp/soak setpoint program sequencer with Avalon-MM register access.
// Assumes pv and remote inputs on clk_sys; discrete inputs come from pins.
`include "rss_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rss_ramp_soak_sequencer #(
  parameter int unsigned TICK_CYC = `RSS_TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  // Process side
  input  wire logic [15:0] pv,
  input  wire logic        remote_sel,
  input  wire logic [15:0] remote_sp,
  input  wire logic        op_screen,
  input  wire logic [4:0]  discrete_input,
  // Outputs
  output var  logic [15:0] sp_out,
  output var  logic        standby,
  output var  logic        lamp
);
  function automatic logic [11:0] rss_range(input logic [4:0] p);
    if (p < 5'h10) begin
      return {p[3:0], 2'h0, p[3:0], 2'h3};
    end else if (p < 5'h18) begin
      return {p[2:0], 3'h0, p[2:0], 3'h7};
    end else if (p < 5'h1C) begin
      return {p[1:0], 4'h0, p[1:0], 4'hF};
    end else if (p < 5'h1E) begin
      return {p[0], 5'h00, p[0], 5'h1F};
    end
    return {6'h00, 6'h3F};
  endfunction : rss_range
  function automatic logic [12:0] rss_units(input logic [12:0] d);
    return {6'h00, d[12:6]} * 13'h003C + {7'h00, d[5:0]};
  endfunction : rss_units
  function automatic logic [15:0] rss_clamp(input logic [15:0] v, lo, hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : rss_clamp
  function automatic logic [15:0] rss_lerp(input logic [15:0] a, b,
                                           input logic [12:0] el, du);
    logic signed [31:0] d;
    d = (signed'({16'h0000, b}) - signed'({16'h0000, a}))
        * signed'({19'h00000, el}) / signed'({19'h00000, du});
    return a + d[15:0];
  endfunction : rss_lerp

  rss_pkg::rss_state_type state_q;
  logic [12:0] ctrl_q, el_q;
  logic [31:0] limit_q, band_q, rdata_d;
  logic [15:0] lsp_q, gsp_q, start_q;
  logic [5:0]  step_q, first_q, last_q;
  logic        wait_q, pon_q, blink_q;
  logic [4:0]  di_m_q, di_q;
  logic [25:0] cyc_q;
  logic [5:0]  sec_q;
  logic [15:0] tgt_mem [64];
  logic [25:0] dur_mem [64];

  // Control fields
  logic [1:0]  cmd;
  logic [3:0]  mode;
  logic        run_req, hold, stop, active, tick, sec_p, in_band, oob;
  logic [4:0]  pat;
  logic [11:0] rng;
  logic [15:0] tgt, lo, hi;
  logic [12:0] rdur, sdur;
  logic        wr_en, inst;
  assign cmd     = ctrl_q[`RSS_F_CMD];
  assign mode    = ctrl_q[`RSS_F_MODE];
  assign stop    = cmd == rss_pkg::RSS_STOP;
  assign hold    = cmd == rss_pkg::RSS_HOLD;
  assign run_req = cmd == rss_pkg::RSS_RUN || (pon_q && mode[3]);
  assign active  = state_q != rss_pkg::RSS_IDLE;
  assign pat     = ctrl_q[`RSS_F_PAT] == `RSS_PAT_DI ?
                   (di_q == `RSS_PAT_DI ? `RSS_PAT_ALL : di_q) : ctrl_q[`RSS_F_PAT];
  assign rng     = rss_range(pat);
  assign lo      = limit_q[15:0];
  assign hi      = limit_q[31:16];
  assign tgt     = tgt_mem[step_q];
  assign rdur    = rss_units(dur_mem[step_q][12:0]);
  assign sdur    = rss_units(dur_mem[step_q][25:13]);
  assign in_band = {1'b0, pv} + {1'b0, band_q[15:0]} >= {1'b0, gsp_q} &&
                   {1'b0, pv} <= {1'b0, gsp_q} + {1'b0, band_q[31:16]};
  assign oob     = ctrl_q[`RSS_F_GSOAK] && !in_band &&
                   (state_q == rss_pkg::RSS_RAMP || state_q == rss_pkg::RSS_SOAK);
  assign wr_en   = write && !wait_q;
  assign inst    = address[`RSS_STEP_BIT];

  // Discrete inputs cross in from pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      di_m_q <= 5'h00;
      di_q   <= 5'h00;
    end else begin
      di_m_q <= discrete_input;
      di_q   <= di_m_q;
    end
  end

  // Time base: seconds, and minutes for hh:mm units
  assign sec_p = cyc_q == 26'(TICK_CYC - 1);
  assign tick  = sec_p && (!ctrl_q[`RSS_F_UNIT] || sec_q == `RSS_MIN_SECS);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q   <= 26'h0000000;
      sec_q   <= 6'h00;
      blink_q <= 1'b0;
    end else begin
      cyc_q <= sec_p ? 26'h0000000 : cyc_q + 26'h0000001;
      if (sec_p) begin
        sec_q   <= sec_q == `RSS_MIN_SECS ? 6'h00 : sec_q + 6'h01;
        blink_q <= !blink_q;
      end
    end
  end

  // Bus handshake: one wait cycle, data latched on the first edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q   <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      if ((read || write) && wait_q) begin
        wait_q   <= 1'b0;
        readdata <= read ? rdata_d : 32'h00000000;
      end else begin
        wait_q <= 1'b1;
      end
    end
  end
  assign waitrequest = wait_q;

  // Read decode; durations come back in their write layout, unmapped reads zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (inst) begin
      rdata_d = address[2] ? {3'h0, dur_mem[address[8:3]][25:13], 3'h0,
                              dur_mem[address[8:3]][12:0]}
                           : {16'h0000, tgt_mem[address[8:3]]};
    end else begin
      case (address)
        `RSS_OFS_CTRL:  rdata_d = {19'h00000, ctrl_q};
        `RSS_OFS_LIMIT: rdata_d = limit_q;
        `RSS_OFS_BAND:  rdata_d = band_q;
        `RSS_OFS_LSP:   rdata_d = {16'h0000, lsp_q};
        `RSS_OFS_STAT:  rdata_d = {20'h00000, state_q == rss_pkg::RSS_RAMP, step_q,
                                   state_q == rss_pkg::RSS_END, oob, hold && active,
                                   active && cmd == rss_pkg::RSS_RUN, !active};
        `RSS_OFS_GSP:   rdata_d = {16'h0000, gsp_q};
        default:        rdata_d = 32'h00000000;
      endcase
    end
  end

  // Configuration registers; pattern and mode are host's to keep still when active
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= `RSS_CTRL_RST;
      limit_q <= `RSS_LIM_RST;
      band_q  <= 32'h00000000;
      lsp_q   <= 16'h0000;
    end else if (wr_en && !inst) begin
      case (address)
        `RSS_OFS_CTRL:  ctrl_q <= writedata[12:0];
        `RSS_OFS_LIMIT: limit_q <= writedata;
        `RSS_OFS_BAND:  band_q <= {rss_clamp(writedata[31:16], 16'h0000, `RSS_HALF_FS),
                                   rss_clamp(writedata[15:0], 16'h0000, `RSS_HALF_FS)};
        `RSS_OFS_LSP:   if (!active) lsp_q <= writedata[15:0];
        default:        ;
      endcase
    end
  end

  // Step table; durations saturate at 99:59, targets at the limits
  always_ff @(posedge clk_sys) begin
    if (wr_en && inst) begin
      if (address[2]) begin
        dur_mem[address[8:3]] <= {
          writedata[28:22] > `RSS_MAX_MAJ ? `RSS_MAX_MAJ : writedata[28:22],
          writedata[21:16] > `RSS_MAX_MIN ? `RSS_MAX_MIN : writedata[21:16],
          writedata[12:6] > `RSS_MAX_MAJ ? `RSS_MAX_MAJ : writedata[12:6],
          writedata[5:0] > `RSS_MAX_MIN ? `RSS_MAX_MIN : writedata[5:0]};
      end else begin
        tgt_mem[address[8:3]] <= rss_clamp(writedata[15:0], lo, hi);
      end
    end
  end

  // Sequencer; hold leaves timer and setpoint untouched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rss_pkg::RSS_IDLE;
      step_q  <= 6'h00;
      first_q <= 6'h00;
      last_q  <= 6'h00;
      el_q    <= 13'h0000;
      gsp_q   <= 16'h0000;
      start_q <= 16'h0000;
      pon_q   <= 1'b1;
    end else begin
      pon_q <= 1'b0;
      case (state_q)
        rss_pkg::RSS_IDLE: begin
          if (run_req) begin
            first_q <= rng[11:6];
            last_q  <= rng[5:0];
            step_q  <= rng[11:6];
            start_q <= pv;
            gsp_q   <= pv;
            el_q    <= 13'h0000;
            state_q <= rss_pkg::RSS_RAMP;
          end
        end
        rss_pkg::RSS_RAMP: begin
          if (stop) state_q <= rss_pkg::RSS_IDLE;
          else if (!hold) begin
            if (rdur == 13'h0000 || (tick && el_q + 13'h0001 >= rdur)) begin
              gsp_q   <= tgt;
              el_q    <= 13'h0000;
              state_q <= rss_pkg::RSS_SOAK;
            end else if (tick) begin
              el_q  <= el_q + 13'h0001;
              gsp_q <= rss_lerp(start_q, tgt, el_q + 13'h0001, rdur);
            end
          end
        end
        rss_pkg::RSS_SOAK: begin
          if (stop) state_q <= rss_pkg::RSS_IDLE;
          else if (!hold) begin
            if (sdur == 13'h0000 || (tick && (in_band || !ctrl_q[`RSS_F_GSOAK])
                && el_q + 13'h0001 >= sdur)) begin
              el_q    <= 13'h0000;
              start_q <= gsp_q;
              if (step_q != last_q) begin
                step_q  <= step_q + 6'h01;
                state_q <= rss_pkg::RSS_RAMP;
              end else if (mode[0]) begin
                step_q  <= first_q;
                state_q <= rss_pkg::RSS_RAMP;
              end else begin
                state_q <= rss_pkg::RSS_END;
              end
            end else if (tick && (in_band || !ctrl_q[`RSS_F_GSOAK])) begin
              el_q <= el_q + 13'h0001;
            end
          end
        end
        rss_pkg::RSS_END: begin
          if (stop) state_q <= rss_pkg::RSS_IDLE;
        end
        default: state_q <= rss_pkg::RSS_IDLE;
      endcase
    end
  end

  // Outputs: remote wins, else program setpoint when active, else local
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sp_out  <= 16'h0000;
      standby <= 1'b0;
      lamp    <= 1'b0;
    end else begin
      sp_out  <= remote_sel ? remote_sp :
                 active ? rss_clamp(gsp_q, lo, hi) : lsp_q;
      standby <= (!active && mode[1]) ||
                 (state_q == rss_pkg::RSS_END && mode[2] && !mode[0]);
      lamp    <= state_q == rss_pkg::RSS_END ||
                 (active && (!hold || op_screen) && blink_q);
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_busy;
    active && !stop && !hold;
  endsequence
  sequence s_frozen;
    hold && (state_q == rss_pkg::RSS_RAMP || state_q == rss_pkg::RSS_SOAK);
  endsequence
  stop_halts_a: assert property (active && stop |=> !active)
    else $error("stop did not halt program");
  lsp_lock_a: assert property (wr_en && address == `RSS_OFS_LSP && active
                               |=> $stable(lsp_q))
    else $error("local setpoint changed while active");
  blk4_a: assert property (!active && run_req && pat < 5'h10
                           |=> step_q == {pat[3:0], 2'h0})
    else $error("four-step block start wrong");
  wide_a: assert property (!active && run_req && pat == `RSS_PAT_ALL
                           |=> step_q == 6'h00 && last_q == 6'h3F)
    else $error("full range wrong");
  di_pat_a: assert property (!active && run_req && ctrl_q[`RSS_F_PAT] == `RSS_PAT_DI
                             && di_q < 5'h10 |=> step_q == {di_q[3:0], 2'h0})
    else $error("input pattern ignored");
  hold_frz_a: assert property (s_frozen ##1 s_frozen |-> $stable(gsp_q) && $stable(el_q))
    else $error("hold did not freeze");
  zero_skip_a: assert property (s_busy ##0 (state_q == rss_pkg::RSS_RAMP
                                && rdur == 13'h0000) |=> state_q == rss_pkg::RSS_SOAK)
    else $error("zero ramp not skipped");
  gs_gate_a: assert property (s_busy ##0 (state_q == rss_pkg::RSS_SOAK && oob)
                              |=> $stable(el_q) || state_q != rss_pkg::RSS_SOAK)
    else $error("soak counted out of band");
  lamp_end_a: assert property (state_q == rss_pkg::RSS_END ##1 state_q == rss_pkg::RSS_END
                               |-> lamp)
    else $error("end lamp not steady");
  clamp_a: assert property (active && !remote_sel && lo <= hi ##1 $stable(limit_q)
                            |-> sp_out >= lo && sp_out <= hi)
    else $error("setpoint escaped limits");
endmodule : rss_ramp_soak_sequencer
`default_nettype wire

// [dv/rss_plant_model.sv]
// Plant model: process value slews one count per cycle toward a goal.
// Assumes the bench sets the goal and shares clk_sys with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module rss_plant_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Goal and measured value
  input  wire logic [15:0] goal,
  output var  logic [15:0] pv
);
  // Slow slew, so band entry takes a known span
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pv <= 16'h0000;
    end else if (pv < goal) begin
      pv <= pv + 16'h0001;
    end else if (pv > goal) begin
      pv <= pv - 16'h0001;
    end
  end
endmodule : rss_plant_model
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the ramp/soak sequencer over Avalon-MM.
// Assumes rss_cfg.svh, rss_pkg and the plant model are compiled first.
`include "rss_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  address = 10'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [15:0] pv;
  logic [15:0] goal = 16'h0000;
  logic        remote_sel = 1'b0;
  logic [15:0] remote_sp = 16'h0ABC;
  logic        op_screen = 1'b0;
  logic [4:0]  discrete_input = 5'h00;
  logic [15:0] sp_out;
  logic        standby;
  logic        lamp;
  logic [31:0] q;
  int          miscompares = 0;
  int          check_count = 0;
  localparam logic [9:0] CTRL = `RSS_OFS_CTRL;
  localparam logic [9:0] STAT = `RSS_OFS_STAT;
  localparam logic [9:0] GSP = `RSS_OFS_GSP;
  localparam logic [9:0] LSP = `RSS_OFS_LSP;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  rss_ramp_soak_sequencer #(.TICK_CYC(4)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pv(pv),
    .remote_sel(remote_sel), .remote_sp(remote_sp), .op_screen(op_screen),
    .discrete_input(discrete_input), .sp_out(sp_out), .standby(standby), .lamp(lamp));
  rss_plant_model u_plant (.clk_sys(clk_sys), .rst_n(rst_n), .goal(goal), .pv(pv));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // Request held until waitrequest is sampled low; bounded wait
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a; writedata <= d; read <= !wr; write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    q = readdata;
    if (n >= 100) miscompares++;
    read <= 1'b0; write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    bus(1'b0, a, 32'h00000000);
  endtask : rd
  // Polls one status bit; the read count bounds the wait
  task automatic wait_stat(input int b, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd(STAT);
      if (q[b] === v) break;
    end
    check(32'(q[b]), 32'(v));
  endtask : wait_stat
  function automatic logic [31:0] ctrl(input logic [1:0] c, input int p, input logic [3:0] m,
                                       input logic g);
    return {19'h00000, g, m, 1'b0, 5'(p), c};
  endfunction : ctrl
  function automatic logic [5:0] first_step(input int p);
    if (p < 16) return 6'(4 * p);
    if (p < 24) return 6'(8 * (p - 16));
    if (p < 28) return 6'(16 * (p - 24));
    if (p < 30) return 6'(32 * (p - 28));
    return 6'h00;
  endfunction : first_step
  function automatic logic [9:0] stp(input int n, input int w);
    return 10'(32'h200 + 8 * n + 4 * w);
  endfunction : stp

  task automatic t_reset();
    check(32'(waitrequest), 32'h1);
    rst_n <= 1'b1;
    cyc(1);
    rd(CTRL); check(q, 32'(`RSS_CTRL_RST));
    rd(`RSS_OFS_LIMIT); check(q, `RSS_LIM_RST);
    wr(10'h100, 32'hFFFFFFFF); rd(10'h100); check(q, 32'h0);
    check({15'h0, sp_out, standby}, 32'h0);
  endtask : t_reset
  // Every pattern code, then inputs; pattern only changed while stopped
  task automatic t_patterns();
    for (int n = 0; n < 64; n++) begin
      wr(stp(n, 0), 32'(16'h1000 + n));
      wr(stp(n, 1), 32'h1FFF0000);
    end
    rd(stp(5, 1)); check(q, {3'h0, `RSS_MAX_MAJ, `RSS_MAX_MIN, 16'h0});
    for (int p = 0; p < 31; p++) begin
      wr(CTRL, ctrl(rss_pkg::RSS_RUN, p, 4'h0, 1'b0));
      cyc(3); rd(STAT); check(32'(q[10:5]), 32'(first_step(p)));
      rd(GSP); check(q, 32'(16'h1000 + first_step(p)));
      wr(CTRL, ctrl(rss_pkg::RSS_STOP, p, 4'h0, 1'b0));
    end
    for (int d = 1; d < 30; d += 14) begin
      discrete_input <= 5'(d); cyc(4);
      wr(CTRL, ctrl(rss_pkg::RSS_RUN, 31, 4'h0, 1'b0));
      cyc(3); rd(STAT); check(32'(q[10:5]), 32'(first_step(d)));
      wr(CTRL, ctrl(rss_pkg::RSS_STOP, 31, 4'h0, 1'b0));
    end
    wr(`RSS_OFS_LIMIT, 32'h20000100); wr(stp(9, 0), 32'h3000);
    rd(stp(9, 0)); check(q, 32'h2000);
    wr(`RSS_OFS_LIMIT, `RSS_LIM_RST);
  endtask : t_patterns
  // Ramp, hold, limits, remote, end and stop on steps 0 to 3
  task automatic t_ramp();
    int t;
    logic l;
    wr(stp(0, 0), 32'h400); wr(stp(0, 1), 32'h00280008);
    for (int n = 1; n < 4; n++) wr(stp(n, 1), 32'h0);
    wr(LSP, 32'h123); cyc(2); check(32'(sp_out), 32'h123);
    wr(CTRL, ctrl(rss_pkg::RSS_RUN, 0, 4'h4, 1'b0)); cyc(12);
    rd(GSP); check(32'(q > 0 && q < 32'h400), 32'h1);
    wr(CTRL, ctrl(rss_pkg::RSS_HOLD, 0, 4'h4, 1'b0)); rd(GSP); t = q;
    cyc(20); rd(GSP); check(q, 32'(t));
    rd(STAT); check(32'(q[2]), 32'h1);
    for (int i = 0; i < 10; i++) begin
      cyc(1); check(32'(lamp), 32'h0);
    end
    op_screen <= 1'b1;
    wr(LSP, 32'h456);
    wr(CTRL, ctrl(rss_pkg::RSS_RUN, 0, 4'h4, 1'b0));
    wait_stat(11, 1'b0, 30); rd(GSP); check(q, 32'h400);
    // Blink toggles once per time-base second: five changes in twenty cycles
    t = 0;
    l = lamp;
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      if (lamp !== l) t++;
      l = lamp;
    end
    check(32'(t), 32'h5);
    wr(`RSS_OFS_LIMIT, 32'h03000000); cyc(2); check(32'(sp_out), 32'h300);
    rd(stp(0, 0)); check(q, 32'h400);
    wr(`RSS_OFS_LIMIT, `RSS_LIM_RST);
    remote_sel <= 1'b1; cyc(3); check(32'(sp_out), 32'hABC);
    rd(STAT); check(32'(q[1]), 32'h1);
    remote_sel <= 1'b0; cyc(3); check(32'(sp_out), 32'h400);
    wait_stat(4, 1'b1, 100); check(32'({lamp, standby}), 32'h3);
    wr(CTRL, ctrl(rss_pkg::RSS_STOP, 0, 4'h4, 1'b0)); cyc(3);
    check(32'({lamp, standby}), 32'h0);
    rd(LSP); check(q, 32'h123);
    wr(LSP, 32'h456); rd(LSP); check(q, 32'h456);
    wr(CTRL, ctrl(rss_pkg::RSS_STOP, 0, 4'h2, 1'b0)); cyc(2); check(32'(standby), 32'h1);
  endtask : t_ramp
  // Soak counts only with pv inside the band
  task automatic t_gsoak();
    wr(`RSS_OFS_BAND, 32'hFFFF0010); rd(`RSS_OFS_BAND); check(q, 32'h7FFF0010);
    wr(stp(0, 1), 32'h00020000);
    wr(CTRL, ctrl(rss_pkg::RSS_RUN, 0, 4'h0, 1'b1)); cyc(3);
    rd(STAT); check(32'(q[3]), 32'h1);
    cyc(60); rd(STAT); check(32'(q[4]), 32'h0);
    goal <= 16'h400;
    wait_stat(4, 1'b1, 500);
    wr(CTRL, ctrl(rss_pkg::RSS_STOP, 0, 4'h0, 1'b0));
    // Repeat mode loops back to the first step instead of ending
    wr(CTRL, ctrl(rss_pkg::RSS_RUN, 0, 4'h1, 1'b0));
    cyc(60);
    rd(STAT);
    check(32'(q[4:1]), 32'h1);
    wr(CTRL, ctrl(rss_pkg::RSS_STOP, 0, 4'h1, 1'b0));
  endtask : t_gsoak

  initial begin
    cyc(20);
    t_reset();
    t_patterns();
    t_ramp();
    t_gsoak();
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    cyc(60000);
    miscompares++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
